// file: hdl/adc_clock_cfg_map.svh
// offsets, field positions, reset values and counts of the clock config block
`ifndef ADC_CLOCK_CFG_MAP_SVH
`define ADC_CLOCK_CFG_MAP_SVH

// register addresses
`define CLOCK_SOURCE_DIVIDER_CFG_ADDR 8'h0D
`define MODULATOR_CLOCK_OVERSAMPLE_CFG_ADDR 8'h0E
`define CLOCK_STATUS_ADDR 8'h20

// reset values
`define CLOCK_SOURCE_DIVIDER_CFG_RESET 8'h08
`define MODULATOR_CLOCK_OVERSAMPLE_CFG_RESET 8'h86

// field reset codes, matching the two register reset values
`define SRC_SEL_RESET 1'h0
`define SRC_DIV_RESET 3'h4
`define MOD_DIV_RESET 3'h4
`define OVERSAMPLE_RESET 4'h6

// first register fields
`define SRC_SEL_BIT 7
`define SRC_DIV_MSB 3
`define SRC_DIV_LSB 1

// second register fields
`define MOD_DIV_MSB 7
`define MOD_DIV_LSB 5
`define OVERSAMPLE_MSB 3
`define OVERSAMPLE_LSB 0

// divide ratios
`define RATIO_WIDTH 13
`define DIV_RATIO_ONE 13'h0001
`define STAGE_COUNT 3

`endif

// file: hdl/adc_clock_cfg_pkg.sv
// types and ratio lookups of the clock config block
package adc_clock_cfg_pkg;

    typedef logic [2:0] div_code_t;
    typedef logic [3:0] oversample_code_t;
    typedef logic [12:0] ratio_t;

    // pin divider ratio: twice the code, code zero passes straight through
    function automatic ratio_t div_ratio(input div_code_t code);
        ratio_t r;
        r = 13'h0001;
        if (code != 3'h0) begin
            r = {9'h000, code, 1'b0};
        end
        return r;
    endfunction : div_ratio

    // oversampling ratio, code 0 is the largest, code 15 the smallest
    function automatic ratio_t oversample_table(input oversample_code_t code);
        ratio_t r;
        r = 13'h0020;
        case (code)
            4'h0: r = 13'h1000;
            4'h1: r = 13'h0800;
            4'h2: r = 13'h0400;
            4'h3: r = 13'h0320;
            4'h4: r = 13'h0300;
            4'h5: r = 13'h0200;
            4'h6: r = 13'h0190;
            4'h7: r = 13'h0180;
            4'h8: r = 13'h0100;
            4'h9: r = 13'h00C8;
            4'hA: r = 13'h00C0;
            4'hB: r = 13'h0080;
            4'hC: r = 13'h0060;
            4'hD: r = 13'h0040;
            4'hE: r = 13'h0030;
            default: r = 13'h0020;
        endcase
        return r;
    endfunction : oversample_table

endpackage : adc_clock_cfg_pkg

// file: hdl/clock_event_divider.sv
// divides a stream of one-cycle events by a programmable ratio
`include "adc_clock_cfg_map.svh"
module clock_event_divider
    import adc_clock_cfg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // incoming events and ratio
    input wire logic i_tick,
    input wire ratio_t i_ratio,
    // divided event, one cycle
    output logic o_tick
);

    ratio_t count; // events seen in the current period

    // count events; a ratio shrunk below the count wraps on the next event
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            count <= 13'h0000;
        end else if (i_tick) begin
            if (count + 13'h0001 >= i_ratio) begin
                count <= 13'h0000;
            end else begin
                count <= count + 13'h0001;
            end
        end
    end

    // output pulse registered, one cycle after the closing event
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= i_tick && (count + 13'h0001 >= i_ratio);
        end
    end

endmodule : clock_event_divider

// file: hdl/adc_clock_config_regs.sv
// clock source, divider and oversampling registers with their clock chain
// how the clock chain works
// a rising edge on the chosen pin is one source event; three event
// dividers follow: the source divider, the modulator divider and the
// oversampling stage, each firing once per ratio events of the one before
// divider fields: ratio is twice the code, code zero passes every event
// oversampling field picks one of sixteen ratios, 4096 down to 32
// the internal clock output toggles per source divider event, so its
// period is twice that divider's event spacing
// the pins are plain levels on i_clk: a pin must sit high for a cycle
// and low for a cycle before its next edge counts, so the fastest
// usable source is half of i_clk
// each stage adds a register, so outputs trail the pin edge by a few
// cycles; only rates are promised, not phase
// a ratio write takes effect at once and never restarts a stage, so a
// period in progress may close early when a ratio shrinks
// reserved bits are dropped on write; software must write zeros there
// no interrupt of its own; software polls the status count
`include "adc_clock_cfg_map.svh"
module adc_clock_config_regs
    import adc_clock_cfg_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // clock pins, levels sampled on i_clk
    input wire logic i_crystal_in_ext_clock_pin,
    input wire logic i_serial_clock_pin,
    // derived clocks and events
    output logic o_conv_clock_source_sel,
    output logic o_internal_conv_clock,
    output logic o_modulator_tick,
    output logic o_data_ready
);

    // configuration fields
    logic conv_clock_source_sel; // 0 crystal pin, 1 serial clock pin
    div_code_t source_divider; // divides the chosen source
    div_code_t modulator_clock_divider; // internal clock to modulator
    oversample_code_t oversample_ratio_code; // oversampling ratio code

    // pin edge detection
    logic crystal_last; // previous crystal pin level
    logic serial_last; // previous serial clock pin level
    logic source_edge; // rising edge on the chosen pin

    // divider chain; stage_tick[0] is the pin edge
    // and stage_tick[s+1] leaves stage s
    logic [`STAGE_COUNT:0] stage_tick; // event stream into each stage
    ratio_t stage_ratio [`STAGE_COUNT]; // ratio of each stage
    logic [7:0] data_count; // completed conversions, wraps

    // register writes; reserved bits are not stored and read as zero
    // a stray one in a reserved place is simply dropped
    // only bit 7 and bits 3:1 are kept
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            conv_clock_source_sel <= `SRC_SEL_RESET;
            source_divider <= `SRC_DIV_RESET;
        end else if (i_wr && i_addr == `CLOCK_SOURCE_DIVIDER_CFG_ADDR) begin
            conv_clock_source_sel <= i_wdata[`SRC_SEL_BIT];
            source_divider <=
                i_wdata[`SRC_DIV_MSB:`SRC_DIV_LSB];
        end
    end

    // second register write
    // new codes reach the chain in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            modulator_clock_divider <= `MOD_DIV_RESET;
            oversample_ratio_code <= `OVERSAMPLE_RESET;
        end else if (i_wr &&
                     i_addr == `MODULATOR_CLOCK_OVERSAMPLE_CFG_ADDR) begin
            modulator_clock_divider <=
                i_wdata[`MOD_DIV_MSB:`MOD_DIV_LSB];
            oversample_ratio_code <=
                i_wdata[`OVERSAMPLE_MSB:`OVERSAMPLE_LSB];
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    // strobes never overlap, so a write and a read never collide here
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `CLOCK_SOURCE_DIVIDER_CFG_ADDR: begin
                    // reserved bits 6:4 and 0 read back zero, not stored
                    o_rdata <= {conv_clock_source_sel, 3'h0,
                                source_divider, 1'b0};
                end
                `MODULATOR_CLOCK_OVERSAMPLE_CFG_ADDR: begin
                    o_rdata <= {modulator_clock_divider, 1'b0,
                                oversample_ratio_code};
                end
                // status: a free running count of finished conversions
                `CLOCK_STATUS_ADDR: begin
                    o_rdata <= data_count; // block state
                end
                // unmapped addresses answer zero instead of stale data
                default: begin
                    o_rdata <= 8'h00; // unmapped
                end
            endcase
        end else begin
            o_rdata <= 8'h00; // data stand for one cycle only
        end
    end

    // sample both pins; inputs already share i_clk
    // both history bits reset low like an idle pin, so no false edge
    // shows up right after reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            crystal_last <= 1'b0;
            serial_last <= 1'b0;
        end else begin
            crystal_last <= i_crystal_in_ext_clock_pin;
            serial_last <= i_serial_clock_pin;
        end
    end

    // rising edge of whichever pin is selected
    // the other pin is ignored altogether
    always_comb begin
        if (conv_clock_source_sel) begin
            source_edge = i_serial_clock_pin && !serial_last;
        end else begin
            source_edge = i_crystal_in_ext_clock_pin && !crystal_last;
        end
    end

    // stage ratios: source divider, modulator divider, oversampling
    // the lookups are small tables, cheap beside the 13 bit counters
    always_comb begin
        stage_ratio[0] = div_ratio(source_divider);
        stage_ratio[1] = div_ratio(modulator_clock_divider);
        stage_ratio[2] = oversample_table(oversample_ratio_code);
    end

    assign stage_tick[0] = source_edge;

    // chain of three dividers, each fed by the previous one's event
    // a ratio change takes effect without restarting later stages
    // stage 0 counts pin edges, stage 1 internal clock events and
    // stage 2 modulator events
    generate
        for (genvar s = 0; s < `STAGE_COUNT; s++) begin : g_stage
            clock_event_divider u_div (
                .i_clk (i_clk),
                .i_rstn (i_rstn),
                .i_tick (stage_tick[s]),
                .i_ratio (stage_ratio[s]),
                .o_tick (stage_tick[s+1])
            );
        end
    endgenerate

    // internal clock toggles per first-stage event, half its event rate
    // a level rather than a pulse, so it can be probed as a clock
    // it is a divided event train, not a clean clock for other logic
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_internal_conv_clock <= 1'b0;
        end else if (stage_tick[1]) begin
            o_internal_conv_clock <= !o_internal_conv_clock;
        end
    end

    // modulator and data events, registered once more for the outputs
    // the extra register keeps every output straight off a flip-flop
    // both pulses last exactly one cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_modulator_tick <= 1'b0;
            o_data_ready <= 1'b0;
        end else begin
            o_modulator_tick <= stage_tick[2];
            o_data_ready <= stage_tick[3];
        end
    end

    // mirror of the source select for the pin multiplexer
    // the copy lags the stored bit by one cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_conv_clock_source_sel <= 1'b0;
        end else begin
            o_conv_clock_source_sel <= conv_clock_source_sel;
        end
    end

    // conversion counter seen by software
    // wraps at 255; software takes the difference of two reads
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data_count <= 8'h00;
        end else if (stage_tick[3]) begin
            data_count <= data_count + 8'h01;
        end
    end

endmodule : adc_clock_config_regs

// file: tb/adc_clock_config_regs_sva.sv
// checker watching the clock configuration block from its ports
module adc_clock_cfg_chk (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // derived clocks and events
    input wire logic o_conv_clock_source_sel,
    input wire logic o_internal_conv_clock,
    input wire logic o_modulator_tick,
    input wire logic o_data_ready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // select output follows bit 7 of the last write, copy may lag a cycle
    a_source_sel_copy: assert property (
        i_wr && i_addr == 8'h0D ##2 1 |->
        o_conv_clock_source_sel == $past(i_wdata[7], 2))
        else $error("source select does not follow write");
    // reserved places of the first register never read back set
    a_first_reserved_zero: assert property (
        i_rd && i_addr == 8'h0D |=> (o_rdata & 8'h71) == 8'h00)
        else $error("first register reserved bits set");
    // reserved bit of the second register never reads back set
    a_second_reserved_zero: assert property (
        i_rd && i_addr == 8'h0E |=> o_rdata[4] == 1'b0)
        else $error("second register reserved bit set");
    // read data only in the cycle after a read strobe
    a_rdata_quiet: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside answer cycle");
    // pin edges are two cycles apart, so no toggle follows a toggle
    a_int_clock_spacing: assert property (
        $changed(o_internal_conv_clock) |=> $stable(o_internal_conv_clock))
        else $error("internal clock toggled twice in a row");
    a_mod_tick_pulse: assert property (
        o_modulator_tick |=> !o_modulator_tick)
        else $error("modulator pulse longer than one cycle");
    // ratio is at least 32 modulator events, so readiness is isolated
    a_ready_isolated: assert property (
        o_data_ready |=> !o_data_ready [*8])
        else $error("data ready too close together");
    c_ready: cover property (o_data_ready);
    c_serial_mod: cover property (o_conv_clock_source_sel && o_modulator_tick);
    c_status_read: cover property (i_rd && i_addr == 8'h20);
endmodule : adc_clock_cfg_chk

// file: tb/tb_adc_clock_config_regs.sv
// self-checking bench for the clock configuration register block
module tb_adc_clock_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic crys_pin = 1'b0, ser_pin = 1'b0; // source pin levels
    logic o_conv_clock_source_sel, o_internal_conv_clock;
    logic o_modulator_tick, o_data_ready;
    logic [15:0] n_tog, n_mod, n_rdy; // event counts since reset
    logic conv_clk_last; // internal clock level one cycle back
    int err_total = 0, compares = 0, cyc = 0;
    adc_clock_config_regs adc_clock_config_regs_i (.i_clk(i_clk),
        .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_crystal_in_ext_clock_pin(crys_pin),
        .i_serial_clock_pin(ser_pin),
        .o_conv_clock_source_sel(o_conv_clock_source_sel),
        .o_internal_conv_clock(o_internal_conv_clock),
        .o_modulator_tick(o_modulator_tick), .o_data_ready(o_data_ready));
    initial forever #2 i_clk = ~i_clk;
    // counters restart with every reset so each scenario starts clean
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            conv_clk_last <= 1'b0;
            n_tog <= 16'h0000;
            n_mod <= 16'h0000;
            n_rdy <= 16'h0000;
        end else begin
            conv_clk_last <= o_internal_conv_clock;
            n_tog <= n_tog + 16'(o_internal_conv_clock != conv_clk_last);
            n_mod <= n_mod + 16'(o_modulator_tick);
            n_rdy <= n_rdy + 16'(o_data_ready);
        end
    end
    // hang guard, well above the longest scenario
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk); // one quiet edge before the next request
    endtask : wr
    // answer stands in the cycle after the strobe; its flop is read at
    // the edge closing that cycle, before it clears
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        chk({8'h00, o_rdata}, {8'h00, exp});
    endtask : rd
    task automatic do_reset();
        i_rstn <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
    endtask : do_reset
    // edges one cycle high, one low: the closest spacing allowed
    task automatic pulses(input logic ser, input int n);
        repeat (n) begin
            if (ser) ser_pin <= 1'b1;
            else crys_pin <= 1'b1;
            @(posedge i_clk);
            ser_pin <= 1'b0;
            crys_pin <= 1'b0;
            @(posedge i_clk);
        end
    endtask : pulses
    // fresh reset, program both registers, edges on each pin, then drain
    task automatic chain(input logic [7:0] s, input logic [7:0] m,
                         input int nc, input int ns);
        do_reset();
        wr(8'h0D, s);
        wr(8'h0E, m);
        pulses(1'b0, nc);
        pulses(1'b1, ns);
        repeat (8) @(posedge i_clk);
    endtask : chain
    task automatic t_regs();
        do_reset();
        rd(8'h0D, 8'h08);
        rd(8'h0E, 8'h86);
        rd(8'h33, 8'h00);
        wr(8'h0D, 8'h8E);
        rd(8'h0D, 8'h8E);
        chk({15'h0000, o_conv_clock_source_sel}, 16'h0001);
        wr(8'h0E, 8'hE5);
        rd(8'h0E, 8'hE5);
    endtask : t_regs
    // ratio 2 on the pin path; the unselected pin must not count
    task automatic t_source();
        chain(8'h02, 8'h86, 16, 16);
        chk(n_tog, 16'd8);
        chk(n_mod, 16'd1);
        chain(8'h82, 8'h06, 16, 6);
        chk(n_tog, 16'd3);
        chk(n_mod, 16'd3);
    endtask : t_source
    task automatic t_oversample();
        chain(8'h00, 8'h0F, 64, 0);
        chk(n_mod, 16'd64);
        chk(n_rdy, 16'd2);
        rd(8'h20, 8'h02);
        chain(8'h00, 8'h2F, 64, 0);
        chk(n_mod, 16'd32);
        chk(n_rdy, 16'd1);
        chain(8'h00, 8'h00, 4096, 0);
        chk(n_mod, 16'd4096);
        chk(n_rdy, 16'd1);
    endtask : t_oversample
    initial begin
        t_regs();
        t_source();
        t_oversample();
        final_report();
    end
endmodule : tb_adc_clock_config_regs
bind adc_clock_config_regs adc_clock_cfg_chk chk_i (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata),
    .o_conv_clock_source_sel(o_conv_clock_source_sel),
    .o_internal_conv_clock(o_internal_conv_clock),
    .o_modulator_tick(o_modulator_tick), .o_data_ready(o_data_ready));
